// file: src/eep_pkg.sv
// Shared constants and types for the serial EEPROM slave and its bus master.
package eep_pkg;
	localparam int          SYS_MHZ       = 250;
	localparam int          T_WR_MS       = 5;
	localparam int          WR_CYCLES_DEF = T_WR_MS * 1000 * SYS_MHZ;
	localparam logic [3:0]  DEV_TYPE      = 4'ha;
	localparam int          ADDR_W        = 17;
	localparam int          MEM_BYTES     = 131072;
	localparam int          PAGE_BYTES    = 256;
	localparam logic [7:0]  ERASED        = 8'hff;
	localparam logic [3:0]  ACK_SLOT      = 4'h8;
	localparam logic [3:0]  BYTE_END      = 4'h9;
	localparam logic [7:0]  REG_CMD       = 8'h00;
	localparam logic [7:0]  REG_STATUS    = 8'h04;
	localparam logic [7:0]  REG_DIV       = 8'h08;
	localparam int          CMD_OP_LSB    = 0;
	localparam int          CMD_NACK_BIT  = 8;
	localparam int          CMD_DATA_LSB  = 16;
	localparam int          ST_BUSY_BIT   = 0;
	localparam int          ST_ACK_BIT    = 1;
	localparam int          ST_RX_LSB     = 8;
	localparam logic [7:0]  DIV_RST       = 8'h03;
	localparam logic [1:0]  OP_START      = 2'h0;
	localparam logic [1:0]  OP_STOP       = 2'h1;
	localparam logic [1:0]  OP_WRITE      = 2'h2;
	localparam logic [1:0]  OP_READ       = 2'h3;

	typedef enum logic [5:0] {
		D_IDLE   = 6'b000001,
		D_DEVADR = 6'b000010,
		D_ADRHI  = 6'b000100,
		D_ADRLO  = 6'b001000,
		D_WDATA  = 6'b010000,
		D_RDATA  = 6'b100000
	} eep_dstate_t;

	typedef enum logic [3:0] {
		H_IDLE  = 4'b0001,
		H_START = 4'b0010,
		H_STOP  = 4'b0100,
		H_BYTE  = 4'b1000
	} eep_hstate_t;
endpackage : eep_pkg

// file: src/eep_link_if.sv
// Two-wire link between the EEPROM slave and the bus master, resolving the open-drain lines.
`timescale 1ns/1ps
interface eep_link_if;
	logic host_scl_o;
	logic host_scl_oe;
	logic host_sda_o;
	logic host_sda_oe;
	logic dev_sda_o;
	logic dev_sda_oe;
	logic scl;
	logic sda;

	// Pull-ups win unless a driver is enabled with a low level.
	assign scl = ~(host_scl_oe & ~host_scl_o);
	assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));

	modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe);
	modport host (input sda, output host_scl_o, output host_scl_oe, output host_sda_o, output host_sda_oe);
endinterface : eep_link_if

// file: src/eep_dev.sv
// Serial EEPROM slave: link decoding, addressing, page buffer, programming cycle and reads.
`timescale 1ns/1ps
module eep_dev
	import eep_pkg::*;
#(
	parameter int WR_CYCLES = WR_CYCLES_DEF
) (
	input  wire logic SYS_CLK,
	input  wire logic RST_N,
	eep_link_if.dev   LINK,
	input  wire logic SELECT_STRAP_LOW,
	input  wire logic SELECT_STRAP_HIGH,
	input  wire logic WRITE_PROTECT,
	output logic      WRITE_BUSY
);
	typedef struct packed {
		eep_dstate_t   state;
		logic [2:0]    scl_p;
		logic [2:0]    sda_p;
		logic [1:0]    strap_lo_p;
		logic [1:0]    strap_hi_p;
		logic [1:0]    wp_p;
		logic [3:0]    cnt;
		logic [7:0]    shreg;
		logic [16:0]   addr;
		logic [8:0]    page;
		logic          mack;
		logic          wp_block;
		logic          have_data;
		logic          busy;
		logic [31:0]   wcnt;
		logic [255:0]  valid;
		logic          sda_oe;
		logic          sda_o;
	} eep_dev_t;

	eep_dev_t    s;
	eep_dev_t    n;
	logic        pb_we;
	logic        mem_we;
	logic        rise;
	logic        fall;
	logic        start;
	logic        stop;
	logic        match;
	logic [7:0]  rd_byte;
	// The array stands in for nonvolatile cells, so it starts erased and reset leaves it alone.
	logic [7:0]  mem [MEM_BYTES] = '{default: ERASED};
	logic [7:0]  pbuf [PAGE_BYTES];

	// Edges are taken from the second and third stages only; the first stage feeds nothing else.
	assign rise  = s.scl_p[1] & ~s.scl_p[2];
	assign fall  = ~s.scl_p[1] & s.scl_p[2];
	assign start = s.scl_p[1] & s.scl_p[2] & ~s.sda_p[1] & s.sda_p[2];
	assign stop  = s.scl_p[1] & s.scl_p[2] & s.sda_p[1] & ~s.sda_p[2];
	assign match = (s.shreg[7:4] == DEV_TYPE)
		& (s.shreg[3] == s.strap_hi_p[1]) & (s.shreg[2] == s.strap_lo_p[1])
		& ~s.busy;
	assign rd_byte = mem[s.addr];

	always_comb begin
		n      = s;
		pb_we  = 1'b0;
		mem_we = 1'b0;
		n.scl_p = {s.scl_p[1:0], LINK.scl};
		n.sda_p = {s.sda_p[1:0], LINK.sda};
		n.strap_lo_p = {s.strap_lo_p[0], SELECT_STRAP_LOW};
		n.strap_hi_p = {s.strap_hi_p[0], SELECT_STRAP_HIGH};
		n.wp_p       = {s.wp_p[0], WRITE_PROTECT};

		// Programming: the buffered page is copied one byte per cycle, then the cycle time runs out.
		if (s.busy) begin
			mem_we = (s.wcnt < PAGE_BYTES) && s.valid[s.wcnt[7:0]];
			n.wcnt = s.wcnt + 32'h1;
			if (s.wcnt == WR_CYCLES - 1) begin
				n.busy  = 1'b0;
				n.valid = '0;
				n.wcnt  = '0;
			end
		end

		if (start) begin
			n.state  = D_DEVADR;
			n.cnt    = 4'h0;
			n.sda_oe = 1'b0;
		end else if (stop) begin
			if (s.state == D_WDATA && s.have_data && !s.wp_block) begin
				n.busy = 1'b1;
				n.wcnt = '0;
			end
			n.state     = D_IDLE;
			n.have_data = 1'b0;
			n.sda_oe    = 1'b0;
		end else if (s.state != D_IDLE) begin
			if (rise) begin
				if (s.cnt < ACK_SLOT && s.state != D_RDATA) begin
					n.shreg = {s.shreg[6:0], s.sda_p[1]};
				end
				if (s.cnt == ACK_SLOT && s.state == D_RDATA) begin
					n.mack = ~s.sda_p[1];
				end
				n.cnt = 4'(s.cnt + 4'h1);
			end else if (fall) begin
				if (s.cnt == ACK_SLOT) begin
					n.sda_oe = 1'b1;
					unique case (s.state)
						D_DEVADR: begin
							if (!match) begin
								n.state  = D_IDLE;
								n.sda_oe = 1'b0;
							end else if (s.shreg[0]) begin
								n.state = D_RDATA;
								n.mack  = 1'b1;
							end else begin
								n.addr[16] = s.shreg[1];
								n.state    = D_ADRHI;
							end
						end
						D_ADRHI: begin
							n.addr[15:8] = s.shreg;
							n.state      = D_ADRLO;
						end
						D_ADRLO: begin
							n.addr[7:0] = s.shreg;
							n.page      = {s.addr[16:8]};
							n.state     = D_WDATA;
						end
						D_WDATA: begin
							if (s.wp_block) begin
								n.sda_oe = 1'b0;
								n.state  = D_IDLE;
							end else begin
								pb_we                = 1'b1;
								n.valid[s.addr[7:0]] = 1'b1;
								n.addr[7:0]          = 8'(s.addr[7:0] + 8'h1);
								n.have_data          = 1'b1;
							end
						end
						D_RDATA: n.sda_oe = 1'b0;
						default: begin
							n.state  = D_IDLE;
							n.sda_oe = 1'b0;
						end
					endcase
				end else if (s.cnt == BYTE_END) begin
					n.cnt    = 4'h0;
					n.sda_oe = 1'b0;
					if (s.state == D_WDATA && !s.have_data) begin
						n.wp_block = s.wp_p[1];
					end
					if (s.state == D_RDATA) begin
						if (s.mack) begin
							n.shreg  = rd_byte;
							n.addr   = 17'(s.addr + 17'h1);
							n.sda_oe = ~rd_byte[7];
						end else begin
							n.state = D_IDLE;
						end
					end
				end else if (s.state == D_RDATA && s.cnt != 4'h0 && s.cnt < ACK_SLOT) begin
					n.sda_oe = ~s.shreg[3'h7 - s.cnt[2:0]];
				end
			end
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			s       <= '0;
			s.state <= D_IDLE;
			s.scl_p <= 3'h7;
			s.sda_p <= 3'h7;
		end else begin
			s <= n;
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (pb_we) begin
			pbuf[s.addr[7:0]] <= s.shreg;
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (mem_we) begin
			mem[{s.page, s.wcnt[7:0]}] <= pbuf[s.wcnt[7:0]];
		end
	end

	assign LINK.dev_sda_oe = s.sda_oe;
	assign LINK.dev_sda_o  = s.sda_o;
	assign WRITE_BUSY      = s.busy;
endmodule : eep_dev

// file: src/eep_host.sv
// Two-wire bus master for the EEPROM, commanded over APB.
`timescale 1ns/1ps
module eep_host
	import eep_pkg::*;
(
	input  wire logic        SYS_CLK,
	input  wire logic        RST_N,
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [7:0]  PADDR,
	input  wire logic [31:0] PWDATA,
	output logic [31:0]      PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	eep_link_if.host         LINK
);
	typedef struct packed {
		eep_hstate_t  state;
		logic [1:0]   q;
		logic [3:0]   bitn;
		logic [7:0]   tick;
		logic [7:0]   div;
		logic [7:0]   shreg;
		logic         rd;
		logic         nack;
		logic         got_ack;
		logic [7:0]   rxdata;
		logic         scl_oe;
		logic         sda_oe;
		logic         od_lvl;
		logic [1:0]   sda_p;
		logic         pready;
		logic         pslverr;
		logic [31:0]  prdata;
	} eep_host_t;

	eep_host_t s;
	eep_host_t n;
	logic      step;
	logic      sda_in;

	assign sda_in = s.sda_p[1];
	assign step   = (s.state != H_IDLE) && (s.tick == s.div);

	always_comb begin
		n        = s;
		n.sda_p  = {s.sda_p[0], LINK.sda};
		n.pready = PSEL & ~PENABLE;
		if (PSEL && !PENABLE) begin
			n.pslverr = !(PADDR == REG_CMD || PADDR == REG_STATUS || PADDR == REG_DIV);
			n.prdata  = '0;
			if (!PWRITE && PADDR == REG_STATUS) begin
				n.prdata[ST_BUSY_BIT]             = s.state != H_IDLE;
				n.prdata[ST_ACK_BIT]              = s.got_ack;
				n.prdata[ST_RX_LSB +: 8]          = s.rxdata;
			end else if (!PWRITE && PADDR == REG_DIV) begin
				n.prdata[7:0] = s.div;
			end
		end
		if (PSEL && PENABLE && s.pready && PWRITE) begin
			if (PADDR == REG_DIV) begin
				n.div = PWDATA[7:0];
			end else if (PADDR == REG_CMD && s.state == H_IDLE) begin
				n.q     = 2'h0;
				n.tick  = 8'h0;
				n.bitn  = 4'h0;
				n.shreg = PWDATA[CMD_DATA_LSB +: 8];
				n.nack  = PWDATA[CMD_NACK_BIT];
				n.rd    = PWDATA[CMD_OP_LSB +: 2] == OP_READ;
				unique case (PWDATA[CMD_OP_LSB +: 2])
					OP_START: n.state = H_START;
					OP_STOP:  n.state = H_STOP;
					OP_WRITE: n.state = H_BYTE;
					OP_READ:  n.state = H_BYTE;
				endcase
			end
		end

		// Each bit takes four quarter steps of div+1 cycles; in a byte SDA moves while SCL is low or as SCL falls, but START and STOP move it while SCL is high.
		if (s.state != H_IDLE) begin
			n.tick = step ? 8'h0 : 8'(s.tick + 8'h1);
		end
		if (step) begin
			n.q = 2'(s.q + 2'h1);
			unique case (s.state)
				H_START: begin
					unique case (s.q)
						2'h0: n.sda_oe = 1'b0;
						2'h1: n.scl_oe = 1'b0;
						2'h2: n.sda_oe = 1'b1;
						2'h3: begin
							n.scl_oe = 1'b1;
							n.state  = H_IDLE;
						end
					endcase
				end
				H_STOP: begin
					unique case (s.q)
						2'h0: n.sda_oe = 1'b1;
						2'h1: n.scl_oe = 1'b0;
						2'h2: n.sda_oe = 1'b0;
						2'h3: n.state  = H_IDLE;
					endcase
				end
				H_BYTE: begin
					unique case (s.q)
						2'h0: begin
							if (s.bitn < ACK_SLOT) begin
								n.sda_oe = ~s.rd & ~s.shreg[7];
							end else begin
								n.sda_oe = s.rd & ~s.nack;
							end
						end
						2'h1: n.scl_oe = 1'b0;
						2'h2: begin
							if (s.bitn < ACK_SLOT) begin
								n.shreg = {s.shreg[6:0], sda_in};
							end else if (!s.rd) begin
								n.got_ack = ~sda_in;
							end
						end
						2'h3: begin
							n.scl_oe = 1'b1;
							n.bitn   = 4'(s.bitn + 4'h1);
							if (s.bitn == ACK_SLOT) begin
								n.rxdata = s.shreg;
								n.sda_oe = 1'b0;
								n.state  = H_IDLE;
							end
						end
					endcase
				end
				default: n.state = H_IDLE;
			endcase
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			s       <= '0;
			s.state <= H_IDLE;
			s.div   <= DIV_RST;
			s.sda_p <= 2'h3;
		end else begin
			s <= n;
		end
	end

	assign PRDATA           = s.prdata;
	assign PREADY           = s.pready;
	assign PSLVERR          = s.pslverr;
	assign LINK.host_scl_oe = s.scl_oe;
	assign LINK.host_scl_o  = s.od_lvl;
	assign LINK.host_sda_oe = s.sda_oe;
	assign LINK.host_sda_o  = s.od_lvl;
endmodule : eep_host

// file: test/eep_link_assertions.sv
// Concurrent checks on the two-wire link between the EEPROM slave and its master.
`timescale 1ns/1ps
module eep_link_assertions #(
	parameter int WR_CYCLES = 300
) (
	input wire logic SYS_CLK,
	input wire logic RST_N,
	input wire logic scl,
	input wire logic sda,
	input wire logic dev_sda_o,
	input wire logic dev_sda_oe,
	input wire logic WRITE_BUSY,
	input wire logic WRITE_PROTECT
);
	// A protect level held this long must have covered the strobe point; at the default divider
	// this limits a write to about twenty-five data bytes between strobe and STOP.
	localparam int WP_LONG = 4000;
	logic        seen_start_ff;
	logic [31:0] busy_cnt_ff;
	logic [15:0] wp_cnt_ff;

	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!RST_N);

	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			seen_start_ff <= 1'b0;
			busy_cnt_ff   <= '0;
			wp_cnt_ff     <= '0;
		end else begin
			if (scl && $fell(sda))
				seen_start_ff <= 1'b1;
			busy_cnt_ff <= WRITE_BUSY ? busy_cnt_ff + 32'h1 : 32'h0;
			if (!WRITE_PROTECT)
				wp_cnt_ff <= 16'h0;
			else if (wp_cnt_ff != 16'hffff)
				wp_cnt_ff <= wp_cnt_ff + 16'h1;
		end
	end

	a_reset_idle: assert property ($rose(RST_N) |-> !dev_sda_oe && !WRITE_BUSY)
		else $error("device not idle after reset");
	a_dev_open_drain: assert property (dev_sda_oe |-> !dev_sda_o)
		else $error("device drives data high");
	a_oe_after_fall: assert property ($changed(dev_sda_oe) |-> !scl)
		else $error("device changed data while clock high");
	a_start_first: assert property (dev_sda_oe |-> seen_start_ff)
		else $error("device drove data before any start");
	a_busy_on_stop: assert property ($rose(WRITE_BUSY) |-> scl && sda)
		else $error("programming began with the link not idle");
	a_busy_hold: assert property ($rose(WRITE_BUSY) |=> WRITE_BUSY [*8])
		else $error("programming cycle cut short");
	a_busy_length: assert property ($fell(WRITE_BUSY) |-> busy_cnt_ff == WR_CYCLES)
		else $error("programming cycle length wrong");
	a_busy_silent: assert property (WRITE_BUSY |-> !dev_sda_oe)
		else $error("device answered while programming");
	a_protect_blocks: assert property ($rose(WRITE_BUSY) |-> wp_cnt_ff < WP_LONG)
		else $error("programming started under write protect");

	c_busy: cover property ($rose(WRITE_BUSY));
	c_ack: cover property ($rose(dev_sda_oe));
	c_stop: cover property (seen_start_ff && scl && $rose(sda));
endmodule : eep_link_assertions

// file: test/tb_i2c_serial_eeprom_slave.sv
// Self-checking bench: an APB-commanded master drives the EEPROM slave over the shared link.
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin failures++; \
	$display("BAD %0t value %h expected %h", $time, g, e); end end
module tb_i2c_serial_eeprom_slave
	import eep_pkg::*;
;
	logic        SYS_CLK, RST_N, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, err;
	logic        SELECT_STRAP_LOW, SELECT_STRAP_HIGH, WRITE_PROTECT, WRITE_BUSY;
	logic [7:0]  PADDR;
	logic [31:0] PWDATA, PRDATA, st;
	int          failures, n_compared, i;
	localparam logic [7:0] RDA = {DEV_TYPE, 2'b01, 2'b01};

	eep_link_if link();
	eep_host u_eep_host (.SYS_CLK, .RST_N, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR,
		.LINK(link));
	eep_dev #(.WR_CYCLES(300)) u_eep_dev (.SYS_CLK, .RST_N, .LINK(link), .SELECT_STRAP_LOW, .SELECT_STRAP_HIGH,
		.WRITE_PROTECT, .WRITE_BUSY);
	eep_link_assertions #(.WR_CYCLES(300)) u_eep_link_assertions (.SYS_CLK, .RST_N, .scl(link.scl), .sda(link.sda),
		.dev_sda_o(link.dev_sda_o), .dev_sda_oe(link.dev_sda_oe), .WRITE_BUSY, .WRITE_PROTECT);

	task automatic finish_test();
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : finish_test

	task automatic bail();
		failures++;
		finish_test();
	endtask : bail

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int   k;
		logic rdy;
		@(posedge SYS_CLK);
		PSEL <= 1'b1;
		PWRITE <= wr;
		PADDR <= a;
		PWDATA <= d;
		@(posedge SYS_CLK);
		PENABLE <= 1'b1;
		// The answer is read while settled before the edge that ends the access, since PREADY drops on that edge.
		for (k = 0; k < 20; k++) begin
			@(negedge SYS_CLK);
			rdy = PREADY;
			st = PRDATA;
			err = PSLVERR;
			@(posedge SYS_CLK);
			if (rdy === 1'b1)
				break;
		end
		if (k == 20)
			bail();
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
	endtask : apb

	// Each link command is waited out on the master's own busy flag.
	task automatic op(input logic [1:0] o, input logic [7:0] d, input logic nk);
		int k;
		apb(1'b1, REG_CMD, {8'h00, d, 7'h00, nk, 6'h00, o});
		for (k = 0; k < 400; k++) begin
			apb(1'b0, REG_STATUS, 32'h0);
			if (st[ST_BUSY_BIT] === 1'b0)
				break;
		end
		if (k == 400)
			bail();
	endtask : op

	task automatic wb(input logic [7:0] b, input logic ack);
		op(OP_WRITE, b, 1'b0);
		`CHK(st[ST_ACK_BIT], ack)
	endtask : wb

	task automatic rb(input logic [7:0] e, input logic nk);
		op(OP_READ, 8'h00, nk);
		`CHK(st[15:8], e)
	endtask : rb

	task automatic seta(input logic [16:0] a);
		op(OP_START, 8'h00, 1'b0);
		wb({DEV_TYPE, 2'b01, a[16], 1'b0}, 1'b1);
		wb(a[15:8], 1'b1);
		wb(a[7:0], 1'b1);
	endtask : seta

	task automatic cur();
		op(OP_START, 8'h00, 1'b0);
		wb(RDA, 1'b1);
	endtask : cur

	task automatic rread(input logic [16:0] a);
		seta(a);
		cur();
	endtask : rread

	task automatic stop();
		op(OP_STOP, 8'h00, 1'b0);
	endtask : stop

	// Acknowledge polling until the programming cycle has ended.
	task automatic wready();
		for (i = 0; i < 20; i++) begin
			op(OP_START, 8'h00, 1'b0);
			op(OP_WRITE, RDA & 8'hfe, 1'b0);
			if (st[ST_ACK_BIT] === 1'b1)
				break;
		end
		if (i == 20)
			bail();
		stop();
	endtask : wready

	initial begin
		SYS_CLK = 1'b0;
		forever #2 SYS_CLK = ~SYS_CLK;
	end

	initial begin
		{RST_N, PSEL, PENABLE, PWRITE, PADDR, PWDATA, SELECT_STRAP_HIGH, WRITE_PROTECT} = '0;
		SELECT_STRAP_LOW = 1'b1;
		failures = 0;
		n_compared = 0;
		repeat (2) @(posedge SYS_CLK);
		RST_N <= 1'b1;
		repeat (3) @(posedge SYS_CLK);
		apb(1'b0, REG_DIV, 32'h0);
		`CHK(st[7:0], DIV_RST)
		apb(1'b0, 8'h0c, 32'h0);
		`CHK({err, st}, {1'b1, 32'h0})
		// The first header runs at a slower divider so the link is seen at more than one rate.
		apb(1'b1, REG_DIV, 32'h5);
		apb(1'b0, REG_DIV, 32'h0);
		`CHK({err, st[7:0]}, {1'b0, 8'h05})
		op(OP_START, 8'h00, 1'b0);
		wb(8'hb4, 1'b0);
		apb(1'b1, REG_DIV, {24'h0, DIV_RST});
		op(OP_START, 8'h00, 1'b0);
		wb(8'ha0, 1'b0);
		stop();
		// Three bytes from the second-last page offset must fold back to the page start.
		seta(17'h102fe);
		wb(8'h11, 1'b1);
		wb(8'h22, 1'b1);
		wb(8'h33, 1'b1);
		stop();
		`CHK(WRITE_BUSY, 1'b1)
		op(OP_START, 8'h00, 1'b0);
		wb(RDA & 8'hfe, 1'b0);
		wready();
		rread(17'h102fe);
		rb(8'h11, 1'b0);
		rb(8'h22, 1'b0);
		rb(8'hff, 1'b1);
		stop();
		rread(17'h10200);
		rb(8'h33, 1'b1);
		stop();
		rread(17'h002fe);
		rb(8'hff, 1'b1);
		stop();
		WRITE_PROTECT <= 1'b1;
		// Held long enough that the checker's protect counter passes its limit before the header.
		repeat (4100) @(posedge SYS_CLK);
		seta(17'h00010);
		wb(8'h5a, 1'b0);
		stop();
		repeat (10) @(posedge SYS_CLK);
		`CHK(WRITE_BUSY, 1'b0)
		WRITE_PROTECT <= 1'b0;
		rread(17'h00010);
		rb(8'hff, 1'b1);
		stop();
		seta(17'h00000);
		wb(8'h3c, 1'b1);
		wb(8'hc3, 1'b1);
		stop();
		wready();
		seta(17'h00000);
		stop();
		repeat (10) @(posedge SYS_CLK);
		`CHK(WRITE_BUSY, 1'b0)
		cur();
		rb(8'h3c, 1'b1);
		stop();
		cur();
		rb(8'hc3, 1'b1);
		stop();
		rread(17'h1ffff);
		rb(8'hff, 1'b0);
		rb(8'h3c, 1'b1);
		stop();
		finish_test();
	end
endmodule : tb_i2c_serial_eeprom_slave
